// File: common/dac_regs_pkg.sv
// Register map, field layout, reset values and state types of the converter test and decode slice
package dac_regs_pkg;

  localparam int ADDR_W   = 15;
  localparam int RW_BIT   = 15;
  localparam int LANES    = 8;
  localparam int CHANNELS = 2;
  localparam int HIST_W   = 15;

  localparam logic [ADDR_W-1:0] ADDR_ERR_REAL   = 15'h014c;
  localparam logic [ADDR_W-1:0] ADDR_ERR_IMAG   = 15'h014d;
  localparam logic [ADDR_W-1:0] ADDR_WORD_HI    = 15'h014e;
  localparam logic [ADDR_W-1:0] ADDR_WORD_LO    = 15'h014f;
  localparam logic [ADDR_W-1:0] ADDR_DIGITAL_TEST_CONTROL   = 15'h0150;
  localparam logic [ADDR_W-1:0] ADDR_DECODE     = 15'h0151;
  localparam logic [ADDR_W-1:0] ADDR_SCHEME     = 15'h0152;
  localparam logic [ADDR_W-1:0] ADDR_PAD        = 15'h01df;
  localparam logic [ADDR_W-1:0] ADDR_GLOBAL_PD  = 15'h0200;
  localparam logic [ADDR_W-1:0] ADDR_LANE_PD    = 15'h0201;

  localparam logic [3:0] RST_PAD       = 4'hf;
  localparam logic       RST_GLOBAL_PD = 1'b1;
  localparam logic [1:0] CS_IDLE       = 2'h3;

  localparam int DIGITAL_TEST_CONTROL_W     = 2;
  localparam int STATIC_EN_BIT  = 1;
  localparam int SHUF_MSB_BIT   = 2;
  localparam int SHUF_MID_BIT   = 1;
  localparam int SHUF_DDR_BIT   = 0;
  localparam int SCHEME_W       = 2;
  localparam int PAD_W          = 4;
  localparam int PAD_SLEW_LSB   = 0;
  localparam int PAD_DRIVE_LSB  = 2;

  localparam logic [4:0] INSTR_BITS = 5'h10;
  localparam logic [4:0] FRAME_BITS = 5'h18;

  localparam int TAP7_A  = 6;
  localparam int TAP7_B  = 5;
  localparam int TAP15_A = 14;
  localparam int TAP15_B = 13;
  localparam logic [3:0] SEED7  = 4'h7;
  localparam logic [3:0] SEED15 = 4'hf;
  localparam logic [7:0] COUNT_MAX = 8'hff;

  typedef enum logic [1:0] {
    PH_INSTR = 2'b00,
    PH_DATA  = 2'b01,
    PH_DONE  = 2'b10
  } spi_phase_t;

  typedef enum logic [1:0] {
    SCHEME_NRZ         = 2'b00,
    SCHEME_SECOND_ZONE = 2'b01,
    SCHEME_RZ          = 2'b10
  } scheme_t;

  typedef struct packed {
    logic [7:0]            word_hi;
    logic [7:0]            word_lo;
    logic [DIGITAL_TEST_CONTROL_W-1:0] digital_test_control;
    logic [7:0]            decode_ctrl;
    logic [SCHEME_W-1:0]   scheme;
    logic [PAD_W-1:0]      pad;
    logic                  global_pd;
    logic [LANES-1:0]      lane_pd;
  } regs_t;

  typedef struct packed {
    logic [1:0]  sclk_sync;
    logic [1:0]  cs_sync;
    logic [1:0]  sdi_sync;
    logic        sclk_prev;
    spi_phase_t  phase;
    logic [4:0]  bit_cnt;
    logic [15:0] instr;
    logic [7:0]  wdata;
    logic [7:0]  tx;
    logic        sdo;
  } spi_t;

  typedef struct packed {
    logic [HIST_W-1:0] hist;
    logic [3:0]        fill;
    logic [7:0]        errors;
  } chk_t;

  typedef struct packed {
    spi_t                 spi;
    regs_t                regs;
    chk_t [CHANNELS-1:0]  chk;
    logic [15:0]          conv_data;
  } state_t;

endpackage

// File: verilog/dac_test_decode_control_regs.sv
// Serial-port register slice: pattern checker, static test word, decoder and receiver power controls
// What this block does
// - Real-channel pattern error count, eight bits, read only, zero at reset.
// - Imaginary-channel pattern error count, eight bits, read only, zero at reset.
// - Static test word in two byte registers, high byte first, zero at reset.
// - Static test enable bit routes stored word to converter data; clear gives normal data.
// - Three scramble enables for top, middle and double-rate segments, clear at reset.
// - Two-bit scheme field: 00 first-zone NRZ, 01 second-zone, 10 return-to-zero.
// - Four-bit pad setting, all ones at reset; low pair slew, high pair drive.
// - Global power-down bit, set at reset, powers down all lanes and bias.
// - Eight per-lane power-down bits, zero at reset, bit n stops lane n.
// - Reserved bits reset to zero; read-only ones ignore writes.
// - Checker compares against 7-bit or 15-bit sequence chosen by polynomial select.
`timescale 1ns/1ps
module dac_test_decode_control_regs
  import dac_regs_pkg::*;
(
  input  wire logic        MCLK_IN,
  input  wire logic        RST_N_IN,
  input  wire logic        CE_IN,
  input  wire logic        SPI_SCLK_IN,
  input  wire logic        SPI_CS_N_IN,
  input  wire logic        SPI_SDI_IN,
  output logic             SPI_SDO_OUT,
  output logic             SPI_SDO_OE_OUT,
  input  wire logic        PATTERN_CHECKER_ENABLE_IN,
  input  wire logic        PATTERN_POLYNOMIAL_SELECT_IN,
  input  wire logic        PATTERN_COUNTER_RESET_IN,
  input  wire logic        SAMPLE_VALID_IN,
  input  wire logic        REAL_BIT_IN,
  input  wire logic        IMAG_BIT_IN,
  input  wire logic [15:0] NORMAL_DATA_IN,
  output logic      [15:0] CONVERTER_DATA_OUT,
  output logic      [15:0] STATIC_TEST_WORD_OUT,
  output logic             STATIC_TEST_ENABLE_OUT,
  output logic             MSB_SEGMENT_SCRAMBLE_OUT,
  output logic             MIDDLE_SEGMENT_SCRAMBLE_OUT,
  output logic             DDR_SEGMENT_SCRAMBLE_OUT,
  output logic             NRZ_MODE_OUT,
  output logic             SECOND_ZONE_MODE_OUT,
  output logic             RZ_MODE_OUT,
  output logic      [1:0]  PORT_PAD_SLEW_OUT,
  output logic      [1:0]  PORT_PAD_DRIVE_OUT,
  output logic      [7:0]  RECEIVER_LANE_POWERDOWN_OUT,
  output logic             RECEIVER_BIAS_POWERDOWN_OUT
);

  state_t                q;
  state_t                d;
  logic                  cs_act;
  logic                  sclk_rise;
  logic                  sclk_fall;
  logic                  sdi_bit;
  logic [ADDR_W-1:0]     next_addr;
  logic [ADDR_W-1:0]     cur_addr;
  logic [7:0]            wr_byte;
  logic                  wr_strobe;
  logic                  rd_load;
  logic [CHANNELS-1:0]   chan_bit;
  logic [CHANNELS-1:0]   pred;
  logic [3:0]            seed_need;

  // Only the second synchroniser stage is looked at
  assign cs_act    = ~q.spi.cs_sync[1];
  assign sclk_rise = q.spi.sclk_sync[1] & ~q.spi.sclk_prev;
  assign sclk_fall = ~q.spi.sclk_sync[1] & q.spi.sclk_prev;
  assign sdi_bit   = q.spi.sdi_sync[1];
  assign cur_addr  = q.spi.instr[ADDR_W-1:0];
  assign next_addr = {q.spi.instr[ADDR_W-2:0], sdi_bit};
  assign wr_byte   = {q.spi.wdata[6:0], sdi_bit};
  assign wr_strobe = cs_act & sclk_rise & (q.spi.phase == PH_DATA) & (q.spi.bit_cnt == FRAME_BITS - 5'h01)
                     & ~q.spi.instr[RW_BIT];
  assign rd_load   = cs_act & sclk_rise & (q.spi.phase == PH_INSTR) & (q.spi.bit_cnt == INSTR_BITS - 5'h01);
  assign chan_bit  = {IMAG_BIT_IN, REAL_BIT_IN};
  assign seed_need = PATTERN_POLYNOMIAL_SELECT_IN ? SEED15 : SEED7;

  // Self-synchronising predictor: next bit from the received history
  for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_pred
    assign pred[ch] = PATTERN_POLYNOMIAL_SELECT_IN ?
                      (q.chk[ch].hist[TAP15_A] ^ q.chk[ch].hist[TAP15_B]) :
                      (q.chk[ch].hist[TAP7_A] ^ q.chk[ch].hist[TAP7_B]);
  end

  function automatic logic [7:0] read_byte(input state_t s, input logic [ADDR_W-1:0] a);
    logic [7:0] v;
    v = 8'h00;
    unique case (a)
      ADDR_ERR_REAL:  v = s.chk[0].errors;
      ADDR_ERR_IMAG:  v = s.chk[1].errors;
      ADDR_WORD_HI:   v = s.regs.word_hi;
      ADDR_WORD_LO:   v = s.regs.word_lo;
      ADDR_DIGITAL_TEST_CONTROL:  v[DIGITAL_TEST_CONTROL_W-1:0] = s.regs.digital_test_control;
      ADDR_DECODE:    v = s.regs.decode_ctrl;
      ADDR_SCHEME:    v[SCHEME_W-1:0] = s.regs.scheme;
      ADDR_PAD:       v[PAD_W-1:0] = s.regs.pad;
      ADDR_GLOBAL_PD: v[0] = s.regs.global_pd;
      ADDR_LANE_PD:   v = s.regs.lane_pd;
      default:        v = 8'h00;
    endcase
    return v;
  endfunction

  always_comb begin
    d = q;
    d.spi.sclk_sync = {q.spi.sclk_sync[0], SPI_SCLK_IN};
    d.spi.cs_sync   = {q.spi.cs_sync[0], SPI_CS_N_IN};
    d.spi.sdi_sync  = {q.spi.sdi_sync[0], SPI_SDI_IN};
    d.spi.sclk_prev = q.spi.sclk_sync[1];

    if (!cs_act) begin
      d.spi.phase   = PH_INSTR;
      d.spi.bit_cnt = 5'h00;
      d.spi.sdo     = 1'b0;
    end else if (sclk_rise) begin
      unique case (q.spi.phase)
        PH_INSTR: begin
          d.spi.instr   = {q.spi.instr[14:0], sdi_bit};
          d.spi.bit_cnt = q.spi.bit_cnt + 5'h01;
          if (rd_load) begin
            d.spi.phase = PH_DATA;
            d.spi.tx    = read_byte(q, next_addr);
          end
        end
        PH_DATA: begin
          d.spi.wdata   = wr_byte;
          d.spi.bit_cnt = q.spi.bit_cnt + 5'h01;
          if (q.spi.bit_cnt == FRAME_BITS - 5'h01) begin
            d.spi.phase = PH_DONE;
          end
        end
        PH_DONE: begin
          d.spi.bit_cnt = q.spi.bit_cnt;
        end
      endcase
    end else if (sclk_fall && q.spi.phase == PH_DATA) begin
      d.spi.sdo = q.spi.tx[7];
      d.spi.tx  = {q.spi.tx[6:0], 1'b0};
    end

    // Read-only addresses and bits are simply not stored
    if (wr_strobe) begin
      unique case (cur_addr)
        ADDR_WORD_HI:   d.regs.word_hi = wr_byte;
        ADDR_WORD_LO:   d.regs.word_lo = wr_byte;
        ADDR_DIGITAL_TEST_CONTROL:  d.regs.digital_test_control = wr_byte[DIGITAL_TEST_CONTROL_W-1:0];
        ADDR_DECODE:    d.regs.decode_ctrl = wr_byte;
        ADDR_SCHEME:    d.regs.scheme = wr_byte[SCHEME_W-1:0];
        ADDR_PAD:       d.regs.pad = wr_byte[PAD_W-1:0];
        ADDR_GLOBAL_PD: d.regs.global_pd = wr_byte[0];
        ADDR_LANE_PD:   d.regs.lane_pd = wr_byte;
        default:        d.regs = q.regs;
      endcase
    end

    for (int ch = 0; ch < CHANNELS; ch++) begin
      if (PATTERN_COUNTER_RESET_IN) begin
        d.chk[ch].errors = 8'h00;
      end else if (PATTERN_CHECKER_ENABLE_IN && SAMPLE_VALID_IN) begin
        d.chk[ch].hist = {q.chk[ch].hist[HIST_W-2:0], chan_bit[ch]};
        // History must fill before predictions mean anything
        if (q.chk[ch].fill < seed_need) begin
          d.chk[ch].fill = q.chk[ch].fill + 4'h1;
        end else if (chan_bit[ch] != pred[ch] && q.chk[ch].errors != COUNT_MAX) begin
          d.chk[ch].errors = q.chk[ch].errors + 8'h01;
        end
      end
      if (!PATTERN_CHECKER_ENABLE_IN) begin
        d.chk[ch].fill = 4'h0;
      end
    end

    d.conv_data = q.regs.digital_test_control[STATIC_EN_BIT] ? {q.regs.word_hi, q.regs.word_lo} : NORMAL_DATA_IN;
  end

  always_ff @(posedge MCLK_IN) begin
    if (!RST_N_IN) begin
      q                <= '0;
      q.spi.cs_sync    <= CS_IDLE;
      q.regs.pad       <= RST_PAD;
      q.regs.global_pd <= RST_GLOBAL_PD;
    end else if (CE_IN) begin
      q <= d;
    end
  end

  assign SPI_SDO_OUT                 = q.spi.sdo;
  assign SPI_SDO_OE_OUT              = cs_act & (q.spi.phase == PH_DATA) & q.spi.instr[RW_BIT];
  assign CONVERTER_DATA_OUT          = q.conv_data;
  assign STATIC_TEST_WORD_OUT        = {q.regs.word_hi, q.regs.word_lo};
  assign STATIC_TEST_ENABLE_OUT      = q.regs.digital_test_control[STATIC_EN_BIT];
  assign MSB_SEGMENT_SCRAMBLE_OUT    = q.regs.decode_ctrl[SHUF_MSB_BIT];
  assign MIDDLE_SEGMENT_SCRAMBLE_OUT = q.regs.decode_ctrl[SHUF_MID_BIT];
  assign DDR_SEGMENT_SCRAMBLE_OUT    = q.regs.decode_ctrl[SHUF_DDR_BIT];
  assign NRZ_MODE_OUT                = scheme_t'(q.regs.scheme) == SCHEME_NRZ;
  assign SECOND_ZONE_MODE_OUT        = scheme_t'(q.regs.scheme) == SCHEME_SECOND_ZONE;
  assign RZ_MODE_OUT                 = scheme_t'(q.regs.scheme) == SCHEME_RZ;
  assign PORT_PAD_SLEW_OUT           = q.regs.pad[PAD_SLEW_LSB +: 2];
  assign PORT_PAD_DRIVE_OUT          = q.regs.pad[PAD_DRIVE_LSB +: 2];
  // Global bit overrides every lane rather than being merged in software
  assign RECEIVER_LANE_POWERDOWN_OUT = q.regs.lane_pd | {LANES{q.regs.global_pd}};
  assign RECEIVER_BIAS_POWERDOWN_OUT = q.regs.global_pd;

  default clocking cb @(posedge MCLK_IN); endclocking
  default disable iff (!RST_N_IN);

  sequence s_write(logic [ADDR_W-1:0] a);
    CE_IN && wr_strobe && cur_addr == a;
  endsequence

  sequence s_count_step(int ch);
    CE_IN && !PATTERN_COUNTER_RESET_IN && PATTERN_CHECKER_ENABLE_IN && SAMPLE_VALID_IN
      && q.chk[ch].fill >= seed_need && chan_bit[ch] != pred[ch] && q.chk[ch].errors != COUNT_MAX;
  endsequence

  property p_real_count_cause;
    $changed(q.chk[0].errors) |-> $past(PATTERN_COUNTER_RESET_IN) || $past(q.chk[0].errors) + 8'h01 == q.chk[0].errors;
  endproperty
  a_real_count_cause: assert property (p_real_count_cause) else $error("real count moved without cause");

  property p_imag_count_step;
    s_count_step(1) |=> q.chk[1].errors == $past(q.chk[1].errors) + 8'h01;
  endproperty
  a_imag_count_step: assert property (p_imag_count_step) else $error("imag count missed an error");

  property p_word_hi_write;
    s_write(ADDR_WORD_HI) |=> STATIC_TEST_WORD_OUT[15:8] == $past(wr_byte) ##1 CONVERTER_DATA_OUT[15:8] ==
      (STATIC_TEST_ENABLE_OUT ? STATIC_TEST_WORD_OUT[15:8] : $past(NORMAL_DATA_IN[15:8])) || !$past(CE_IN);
  endproperty
  a_word_hi_write: assert property (p_word_hi_write) else $error("high byte write not applied");

  property p_static_select;
    CE_IN && STATIC_TEST_ENABLE_OUT |=> CONVERTER_DATA_OUT == $past(STATIC_TEST_WORD_OUT);
  endproperty
  a_static_select: assert property (p_static_select) else $error("static word not on converter data");

  property p_normal_select;
    CE_IN && !STATIC_TEST_ENABLE_OUT |=> CONVERTER_DATA_OUT == $past(NORMAL_DATA_IN);
  endproperty
  a_normal_select: assert property (p_normal_select) else $error("normal data not passed");

  property p_scramble_only_by_write;
    $changed({MSB_SEGMENT_SCRAMBLE_OUT, MIDDLE_SEGMENT_SCRAMBLE_OUT, DDR_SEGMENT_SCRAMBLE_OUT})
      |-> $past(wr_strobe && CE_IN && cur_addr == ADDR_DECODE);
  endproperty
  a_scramble_only_by_write: assert property (p_scramble_only_by_write) else $error("scramble moved unwritten");

  property p_scheme_decode;
    q.regs.scheme != {SCHEME_W{1'b1}} |-> $onehot({NRZ_MODE_OUT, SECOND_ZONE_MODE_OUT, RZ_MODE_OUT})
      && (NRZ_MODE_OUT == (q.regs.scheme == SCHEME_NRZ));
  endproperty
  a_scheme_decode: assert property (p_scheme_decode) else $error("scheme decode wrong");

  property p_pad_write;
    s_write(ADDR_PAD) |=> {PORT_PAD_DRIVE_OUT, PORT_PAD_SLEW_OUT} == $past(wr_byte[PAD_W-1:0]);
  endproperty
  a_pad_write: assert property (p_pad_write) else $error("pad setting write lost");

  property p_global_pd;
    q.regs.global_pd |-> RECEIVER_LANE_POWERDOWN_OUT == {LANES{1'b1}} && RECEIVER_BIAS_POWERDOWN_OUT;
  endproperty
  a_global_pd: assert property (p_global_pd) else $error("global power-down not total");

  property p_lane_pd;
    s_write(ADDR_LANE_PD) ##1 !q.regs.global_pd |-> RECEIVER_LANE_POWERDOWN_OUT == $past(wr_byte);
  endproperty
  a_lane_pd: assert property (p_lane_pd) else $error("lane power-down mismatch");

  property p_scheme_reserved_read;
    CE_IN && rd_load && next_addr == ADDR_SCHEME |=> q.spi.tx[7:SCHEME_W] == '0;
  endproperty
  a_scheme_reserved_read: assert property (p_scheme_reserved_read) else $error("reserved bits read nonzero");

  property p_count_ro;
    CE_IN && wr_strobe && cur_addr == ADDR_ERR_REAL && !PATTERN_CHECKER_ENABLE_IN && !PATTERN_COUNTER_RESET_IN
      |=> $stable(q.chk[0].errors);
  endproperty
  a_count_ro: assert property (p_count_ro) else $error("count took a write");

  property p_seed_quiet;
    CE_IN && q.chk[0].fill < seed_need && !PATTERN_COUNTER_RESET_IN |=> $stable(q.chk[0].errors);
  endproperty
  a_seed_quiet: assert property (p_seed_quiet) else $error("error counted before history filled");

  property p_saturate;
    CE_IN && q.chk[0].errors == COUNT_MAX && !PATTERN_COUNTER_RESET_IN |=> q.chk[0].errors == COUNT_MAX;
  endproperty
  a_saturate: assert property (p_saturate) else $error("count wrapped");

  property p_count_clear;
    CE_IN && PATTERN_COUNTER_RESET_IN |=> q.chk[0].errors == 8'h00 && q.chk[1].errors == 8'h00;
  endproperty
  a_count_clear: assert property (p_count_clear) else $error("count not cleared");

  property p_real_count_step;
    s_count_step(0) |=> q.chk[0].errors == $past(q.chk[0].errors) + 8'h01;
  endproperty
  a_real_count_step: assert property (p_real_count_step) else $error("real count missed an error");

  // Enable low must hold every register, so no serial write can slip through
  property p_ce_freeze;
    !CE_IN |=> $stable(q.regs) && $stable(q.chk);
  endproperty
  a_ce_freeze: assert property (p_ce_freeze) else $error("state moved while clock enable low");

endmodule

// File: test/tb_dac_test_decode_control_regs.sv
// Self-checking testbench for the converter test and decode register slice
`timescale 1ns/1ps
module tb_dac_test_decode_control_regs;
  import dac_regs_pkg::*;
  logic        mclk, rst_n, ce, sclk, cs_n, sdi;
  logic        chk_en, poly_sel, cnt_rst, valid, real_bit, imag_bit;
  logic [15:0] normal_data;
  logic        sdo, sdo_oe, st_en, shuf_msb, shuf_mid, shuf_ddr, nrz, zone2, rz, bias_pd;
  logic [15:0] conv_data, st_word;
  logic [1:0]  slew, drive;
  logic [7:0]  lanes;
  logic [14:0] gen_q;
  logic        oe_seen;
  int          fails;
  int          n_checks;
  logic [14:0] addrs [11] = '{15'h014c, 15'h014d, 15'h014e, 15'h014f, 15'h0150, 15'h0151,
                              15'h0152, 15'h01df, 15'h0200, 15'h0201, 15'h0153};
  logic [7:0]  rst_v [11] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h0f, 8'h01, 8'h00, 8'h00};

  dac_test_decode_control_regs u_dut (
    .MCLK_IN                      (mclk),
    .RST_N_IN                     (rst_n),
    .CE_IN                        (ce),
    .SPI_SCLK_IN                  (sclk),
    .SPI_CS_N_IN                  (cs_n),
    .SPI_SDI_IN                   (sdi),
    .SPI_SDO_OUT                  (sdo),
    .SPI_SDO_OE_OUT               (sdo_oe),
    .PATTERN_CHECKER_ENABLE_IN    (chk_en),
    .PATTERN_POLYNOMIAL_SELECT_IN (poly_sel),
    .PATTERN_COUNTER_RESET_IN     (cnt_rst),
    .SAMPLE_VALID_IN              (valid),
    .REAL_BIT_IN                  (real_bit),
    .IMAG_BIT_IN                  (imag_bit),
    .NORMAL_DATA_IN               (normal_data),
    .CONVERTER_DATA_OUT           (conv_data),
    .STATIC_TEST_WORD_OUT         (st_word),
    .STATIC_TEST_ENABLE_OUT       (st_en),
    .MSB_SEGMENT_SCRAMBLE_OUT     (shuf_msb),
    .MIDDLE_SEGMENT_SCRAMBLE_OUT  (shuf_mid),
    .DDR_SEGMENT_SCRAMBLE_OUT     (shuf_ddr),
    .NRZ_MODE_OUT                 (nrz),
    .SECOND_ZONE_MODE_OUT         (zone2),
    .RZ_MODE_OUT                  (rz),
    .PORT_PAD_SLEW_OUT            (slew),
    .PORT_PAD_DRIVE_OUT           (drive),
    .RECEIVER_LANE_POWERDOWN_OUT  (lanes),
    .RECEIVER_BIAS_POWERDOWN_OUT  (bias_pd)
  );

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string msg);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  // Four MCLK per serial clock level leaves margin over the two-flop synchronisers
  task automatic frame(input logic rw, input logic [14:0] a, input logic [7:0] wd, output logic [7:0] rv);
    logic [23:0] sh;
    sh = {rw, a, wd};
    rv = 8'h00;
    cs_n = 1'b0;
    tick(4);
    for (int i = 0; i < 24; i++) begin
      sdi = sh[23-i];
      tick(4);
      if (i >= 16) rv = {rv[6:0], sdo};
      if (i == 16) oe_seen = sdo_oe;
      sclk = 1'b1;
      tick(4);
      sclk = 1'b0;
    end
    tick(4);
    cs_n = 1'b1;
    sdi  = 1'b0;
    tick(4);
  endtask

  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    logic [7:0] x;
    frame(1'b0, a, d, x);
  endtask

  task automatic rd_chk(input logic [14:0] a, input logic [7:0] e, input string m);
    logic [7:0] x;
    frame(1'b1, a, 8'h00, x);
    check({8'h00, x}, {8'h00, e}, m);
    check({15'h0000, oe_seen}, 16'h0001, "read drives serial output");
  endtask

  // Real bit may be flipped once; a set ones flag forces an all-ones stream that fails every compare once it fills the history
  task automatic feed(input int n, input logic sel, input int flip, input logic ones);
    logic b;
    for (int i = 0; i < n; i++) begin
      b        = sel ? (gen_q[14] ^ gen_q[13]) : (gen_q[6] ^ gen_q[5]);
      gen_q    = {gen_q[13:0], b};
      real_bit = ones | (b ^ (i == flip));
      imag_bit = ones | b;
      valid    = 1'b1;
      tick(1);
    end
    valid = 1'b0;
  endtask

  task automatic end_sim;
    $display("Checks made: %0d, mismatches: %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    #3000000;
    fails++;
    end_sim();
  end

  initial begin
    {rst_n, sclk, sdi, chk_en, poly_sel, cnt_rst, valid, real_bit, imag_bit} = '0;
    {ce, cs_n} = 2'b11;
    normal_data = 16'h1234;
    gen_q = 15'h007f;
    fails = 0;
    n_checks = 0;
    tick(5);
    rst_n = 1'b1;
    tick(2);
    check({9'h000, nrz, zone2, rz, st_en, shuf_msb, shuf_mid, shuf_ddr}, 16'h0040, "reset modes");
    check({3'h0, lanes, bias_pd, slew, drive}, 16'h1fff, "reset power and pad");
    check(st_word, 16'h0000, "reset static word");
    check(conv_data, 16'h1234, "normal data path");
    for (int i = 0; i < 11; i++) rd_chk(addrs[i], rst_v[i], "reset value");
    wr(15'h014e, 8'ha5);
    wr(15'h014f, 8'h3c);
    rd_chk(15'h014e, 8'ha5, "word high byte");
    rd_chk(15'h014f, 8'h3c, "word low byte");
    check(st_word, 16'ha53c, "static word order");
    ce = 1'b0;
    wr(15'h014e, 8'h00);
    ce = 1'b1;
    tick(4);
    check(st_word, 16'ha53c, "write ignored while frozen");
    wr(15'h0150, 8'hff);
    rd_chk(15'h0150, 8'h03, "test control reserved bits");
    check({15'h0000, st_en}, 16'h0001, "static enable set");
    check(conv_data, 16'ha53c, "static word selected");
    wr(15'h0150, 8'h00);
    check(conv_data, 16'h1234, "normal data restored");
    for (int i = 0; i < 3; i++) begin
      wr(15'h0151, 8'h01 << i);
      check({13'h0000, shuf_msb, shuf_mid, shuf_ddr}, 16'h0001 << i, "scramble select");
    end
    wr(15'h0151, 8'hf8);
    rd_chk(15'h0151, 8'hf8, "decode control reserved bits");
    check({13'h0000, shuf_msb, shuf_mid, shuf_ddr}, 16'h0000, "scramble all off");
    for (int i = 0; i < 4; i++) begin
      wr(15'h0152, 8'(i));
      check({13'h0000, nrz, zone2, rz}, (i == 3) ? 16'h0000 : 16'h0004 >> i, "scheme decode");
    end
    wr(15'h0152, 8'hfd);
    rd_chk(15'h0152, 8'h01, "scheme reserved bits");
    wr(15'h01df, 8'hf6);
    rd_chk(15'h01df, 8'h06, "pad reserved bits");
    check({12'h000, drive, slew}, 16'h0006, "pad slew and drive");
    wr(15'h0200, 8'h00);
    check({7'h00, lanes, bias_pd}, 16'h0000, "global power up");
    wr(15'h0201, 8'h5a);
    rd_chk(15'h0201, 8'h5a, "lane power-down readback");
    check({7'h00, lanes, bias_pd}, 16'h00b4, "lane power-down");
    wr(15'h0200, 8'hff);
    rd_chk(15'h0200, 8'h01, "global power-down reserved");
    check({7'h00, lanes, bias_pd}, 16'h01ff, "global power-down overrides");
    wr(15'h014c, 8'h55);
    rd_chk(15'h014c, 8'h00, "read-only count ignores write");
    chk_en = 1'b1;
    feed(80, 1'b0, 50, 1'b0);
    rd_chk(15'h014c, 8'h03, "real count after one flip");
    rd_chk(15'h014d, 8'h00, "imag count clean");
    chk_en = 1'b0;
    cnt_rst = 1'b1;
    tick(2);
    cnt_rst = 1'b0;
    rd_chk(15'h014c, 8'h00, "count cleared");
    poly_sel = 1'b1;
    chk_en = 1'b1;
    feed(60, 1'b1, 40, 1'b0);
    rd_chk(15'h014c, 8'h03, "long sequence one flip");
    rd_chk(15'h014d, 8'h00, "long sequence clean");
    feed(300, 1'b1, -1, 1'b1);
    rd_chk(15'h014c, 8'hff, "real count saturates");
    rd_chk(15'h014d, 8'hff, "imag count saturates");
    cnt_rst = 1'b1;
    tick(2);
    rd_chk(15'h014d, 8'h00, "count held clear");
    cnt_rst = 1'b0;
    chk_en = 1'b0;
    rst_n = 1'b0;
    tick(5);
    rst_n = 1'b1;
    tick(2);
    rd_chk(15'h01df, 8'h0f, "pad reset again");
    check({7'h00, lanes, bias_pd}, 16'h01ff, "power-down after reset");
    end_sim();
  end
endmodule
